// >>> design/lsc_defines.vh
`ifndef LSC_DEFINES_VH
`define LSC_DEFINES_VH

// Register offsets on the serial control port
`define LSC_ADDR_LIMIT        8'h14
`define LSC_ADDR_BEHAV        8'h15

// Reset values
`define LSC_RST_LIMIT         8'hC0
`define LSC_RST_BEHAV         8'h00

// Writable bit masks; reserved positions are zero
`define LSC_MASK_LIMIT        8'hCF
`define LSC_MASK_BEHAV        8'h3F

// Switch-limit field positions
`define LSC_BIT_WARM_RESET    7
`define LSC_BIT_HYST          6
`define LSC_SW3_LIM_HI        3
`define LSC_SW3_LIM_LO        2
`define LSC_SW2_LIM_HI        1
`define LSC_SW2_LIM_LO        0

// Switch-behaviour field positions
`define LSC_BIT_SW3_PFOFF     5
`define LSC_BIT_SW2_PFOFF     4
`define LSC_BIT_SW1_PFOFF     3
`define LSC_BIT_SW3_DCHG      2
`define LSC_BIT_SW2_DCHG      1
`define LSC_BIT_SW1_DCHG      0

`endif

// >>> design/lsc_config_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "lsc_defines.vh"

module lsc_config_regs (
    input  wire       sys_clk,
    input  wire       srst,
    input  wire       reg_wr_en,
    input  wire       reg_rd_en,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wr_data,
    input  wire       password_ok,
    input  wire       power_fail_output_low,
    input  wire       switch1_enable,
    input  wire       switch2_enable,
    input  wire       switch3_enable,
    output reg  [7:0] reg_rd_data,
    output reg        reg_rd_hit,
    output reg        reg_wr_rejected,
    output reg        shared_pin_warm_reset_select,
    output reg        lockout_hysteresis_select,
    output reg  [1:0] switch3_current_limit,
    output reg  [1:0] switch2_current_limit,
    output reg        switch1_on,
    output reg        switch2_on,
    output reg        switch3_on,
    output reg        switch1_discharge,
    output reg        switch2_discharge,
    output reg        switch3_discharge
);

    reg  [7:0] switch_limit_config;
    reg  [7:0] switch_behaviour_config;
    wire       hit_limit;
    wire       hit_behav;
    wire       map_hit;
    wire       wr_ok;
    wire       wr_limit;
    wire       wr_behav;
    wire       rd_limit;
    wire       rd_behav;
    wire [7:0] limit_view;
    wire [7:0] behav_view;
    wire       warm_field;
    wire       hyst_field;
    wire [1:0] sw3_lim_field;
    wire [1:0] sw2_lim_field;
    wire       sw1_kill;
    wire       sw2_kill;
    wire       sw3_kill;
    wire       sw1_dchg;
    wire       sw2_dchg;
    wire       sw3_dchg;
    wire       pf_tripped;
    wire       next_sw1_on;
    wire       next_sw2_on;
    wire       next_sw3_on;
    wire       next_sw1_dis;
    wire       next_sw2_dis;
    wire       next_sw3_dis;

    // Reset images of the limit, pin-role and discharge outputs come from the register reset words; the switch-on outputs reset to zero
    localparam [7:0] RST_LIMIT_WORD = `LSC_RST_LIMIT;
    localparam [7:0] RST_BEHAV_WORD = `LSC_RST_BEHAV;

    // Offset compare shared by the write and read decoders
    function addr_match;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_match = (addr == target);
        end
    endfunction

    // Gate a switch enable with its power-fail kill bit
    function gate_switch;
        input en;
        input pf_kill;
        input pf_trip;
        begin
            gate_switch = en & ~(pf_kill & pf_trip);
        end
    endfunction

    // Discharge only while the switch is off, whatever turned it off
    function discharge_ctl;
        input dchg_en;
        input sw_on;
        begin
            discharge_ctl = dchg_en & ~sw_on;
        end
    endfunction

    assign hit_limit  = addr_match(reg_addr, `LSC_ADDR_LIMIT);
    assign hit_behav  = addr_match(reg_addr, `LSC_ADDR_BEHAV);
    assign map_hit    = hit_limit | hit_behav;
    assign wr_ok      = reg_wr_en & password_ok;
    assign wr_limit   = wr_ok & hit_limit;
    assign wr_behav   = wr_ok & hit_behav;
    assign rd_limit   = reg_rd_en & hit_limit;
    assign rd_behav   = reg_rd_en & hit_behav;
    // The comparator output is active low, so a trip is a zero on the pin
    assign pf_tripped = ~power_fail_output_low;

    // Field views; masking again on read keeps spare bits zero even if storage were upset
    assign limit_view    = switch_limit_config & `LSC_MASK_LIMIT;
    assign behav_view    = switch_behaviour_config & `LSC_MASK_BEHAV;
    assign warm_field    = switch_limit_config[`LSC_BIT_WARM_RESET];
    assign hyst_field    = switch_limit_config[`LSC_BIT_HYST];
    assign sw3_lim_field = switch_limit_config[`LSC_SW3_LIM_HI:`LSC_SW3_LIM_LO];
    assign sw2_lim_field = switch_limit_config[`LSC_SW2_LIM_HI:`LSC_SW2_LIM_LO];
    assign sw1_kill      = switch_behaviour_config[`LSC_BIT_SW1_PFOFF];
    assign sw2_kill      = switch_behaviour_config[`LSC_BIT_SW2_PFOFF];
    assign sw3_kill      = switch_behaviour_config[`LSC_BIT_SW3_PFOFF];
    assign sw1_dchg      = switch_behaviour_config[`LSC_BIT_SW1_DCHG];
    assign sw2_dchg      = switch_behaviour_config[`LSC_BIT_SW2_DCHG];
    assign sw3_dchg      = switch_behaviour_config[`LSC_BIT_SW3_DCHG];

    // Switch-limit register; reserved bits are never stored
    always @(posedge sys_clk) begin
        if (srst) begin
            switch_limit_config <= `LSC_RST_LIMIT;
        end else if (wr_limit) begin
            switch_limit_config <= reg_wr_data & `LSC_MASK_LIMIT;
        end
    end

    // Switch-behaviour register; a locked write leaves it untouched
    always @(posedge sys_clk) begin
        if (srst) begin
            switch_behaviour_config <= `LSC_RST_BEHAV;
        end else if (wr_behav) begin
            switch_behaviour_config <= reg_wr_data & `LSC_MASK_BEHAV;
        end
    end

    // Read port; unmapped offsets read zero
    always @(posedge sys_clk) begin
        if (srst) begin
            reg_rd_data <= 8'h00;
        end else if (rd_limit) begin
            reg_rd_data <= limit_view;
        end else if (rd_behav) begin
            reg_rd_data <= behav_view;
        end else begin
            reg_rd_data <= 8'h00;
        end
    end

    // Status pulses; a locked write is flagged so software can tell it was lost
    always @(posedge sys_clk) begin
        if (srst) begin
            reg_rd_hit      <= 1'h0;
            reg_wr_rejected <= 1'h0;
        end else begin
            reg_rd_hit      <= reg_rd_en & map_hit;
            reg_wr_rejected <= reg_wr_en & map_hit & ~password_ok;
        end
    end

    assign next_sw1_on  = gate_switch(switch1_enable, sw1_kill, pf_tripped);
    assign next_sw2_on  = gate_switch(switch2_enable, sw2_kill, pf_tripped);
    assign next_sw3_on  = gate_switch(switch3_enable, sw3_kill, pf_tripped);
    // Discharge follows the gated state so a power-fail kill also discharges
    assign next_sw1_dis = discharge_ctl(sw1_dchg, next_sw1_on);
    assign next_sw2_dis = discharge_ctl(sw2_dchg, next_sw2_on);
    assign next_sw3_dis = discharge_ctl(sw3_dchg, next_sw3_on);

    // Shared pin role and lockout hysteresis
    always @(posedge sys_clk) begin
        if (srst) begin
            shared_pin_warm_reset_select <= RST_LIMIT_WORD[`LSC_BIT_WARM_RESET];
            lockout_hysteresis_select    <= RST_LIMIT_WORD[`LSC_BIT_HYST];
        end else begin
            shared_pin_warm_reset_select <= warm_field;
            lockout_hysteresis_select    <= hyst_field;
        end
    end

    // Current limit codes; the analog side decodes the two-bit values
    always @(posedge sys_clk) begin
        if (srst) begin
            switch3_current_limit <= RST_LIMIT_WORD[`LSC_SW3_LIM_HI:`LSC_SW3_LIM_LO];
            switch2_current_limit <= RST_LIMIT_WORD[`LSC_SW2_LIM_HI:`LSC_SW2_LIM_LO];
        end else begin
            switch3_current_limit <= sw3_lim_field;
            switch2_current_limit <= sw2_lim_field;
        end
    end

    // Switch one; registered so the analog controls never glitch
    always @(posedge sys_clk) begin
        if (srst) begin
            switch1_on        <= 1'h0;
            switch1_discharge <= RST_BEHAV_WORD[`LSC_BIT_SW1_DCHG];
        end else begin
            switch1_on        <= next_sw1_on;
            switch1_discharge <= next_sw1_dis;
        end
    end

    // Switch two
    always @(posedge sys_clk) begin
        if (srst) begin
            switch2_on        <= 1'h0;
            switch2_discharge <= RST_BEHAV_WORD[`LSC_BIT_SW2_DCHG];
        end else begin
            switch2_on        <= next_sw2_on;
            switch2_discharge <= next_sw2_dis;
        end
    end

    // Switch three
    always @(posedge sys_clk) begin
        if (srst) begin
            switch3_on        <= 1'h0;
            switch3_discharge <= RST_BEHAV_WORD[`LSC_BIT_SW3_DCHG];
        end else begin
            switch3_on        <= next_sw3_on;
            switch3_discharge <= next_sw3_dis;
        end
    end

endmodule // lsc_config_regs

`default_nettype wire

// >>> tb/lsc_config_props.sv
`timescale 1ns/100ps
`default_nettype none
module lsc_config_props (
    input wire logic       sys_clk,
    input wire logic       srst,
    input wire logic       reg_wr_en,
    input wire logic       reg_rd_en,
    input wire logic       password_ok,
    input wire logic       power_fail_output_low,
    input wire logic       switch1_enable,
    input wire logic       switch1_on,
    input wire logic       switch1_discharge,
    input wire logic       reg_rd_hit,
    input wire logic       reg_wr_rejected,
    input wire logic       shared_pin_warm_reset_select,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire logic map = reg_addr == 8'h14 || reg_addr == 8'h15;
    sequence s_lim_wr;
        reg_wr_en && password_ok && reg_addr == 8'h14;
    endsequence
    a_wr_locked: assert property (reg_wr_en && map && !password_ok |=> reg_wr_rejected)
        else $error("locked write not flagged");
    a_wr_taken: assert property (reg_wr_en && password_ok |=> !reg_wr_rejected)
        else $error("open write flagged");
    a_warm_sel: assert property (s_lim_wr |-> ##2
        shared_pin_warm_reset_select == $past(reg_wr_data[7], 2))
        else $error("pin role wrong");
    a_rd_hit: assert property (reg_rd_en && map |=> reg_rd_hit)
        else $error("read hit missing");
    a_rd_unmap: assert property (reg_rd_en && !map |=> reg_rd_data == 8'h00 && !reg_rd_hit)
        else $error("unmapped read not zero");
    a_lim_resv: assert property (reg_rd_en && reg_addr == 8'h14 |=> reg_rd_data[5:4] == 2'h0)
        else $error("limit spare bits set");
    a_beh_resv: assert property (reg_rd_en && reg_addr == 8'h15 |=> reg_rd_data[7:6] == 2'h0)
        else $error("behaviour spare bits set");
    a_pf_idle: assert property (switch1_enable && power_fail_output_low |=> switch1_on)
        else $error("switch off without trip");
    a_dis_on: assert property (switch1_on |-> !switch1_discharge)
        else $error("discharge while on");
    // Shadow of the switch one bits, so the outputs are judged against the rules
    logic kill1_bit;
    logic dchg1_bit;
    always @(posedge sys_clk) begin
        if (srst) begin
            kill1_bit <= 1'h0;
            dchg1_bit <= 1'h0;
        end else if (reg_wr_en && password_ok && reg_addr == 8'h15) begin
            kill1_bit <= reg_wr_data[3];
            dchg1_bit <= reg_wr_data[0];
        end
    end
    a_pf_kill: assert property (!$past(srst) |-> switch1_on ==
        ($past(switch1_enable) && !($past(kill1_bit) && !$past(power_fail_output_low))))
        else $error("switch one gating wrong");
    a_dis_off: assert property (!$past(srst) |-> switch1_discharge ==
        ($past(dchg1_bit) && !switch1_on))
        else $error("switch one discharge wrong");
endmodule // lsc_config_props
bind lsc_config_regs lsc_config_props u_props (
    .sys_clk                      (sys_clk),
    .srst                         (srst),
    .reg_wr_en                    (reg_wr_en),
    .reg_rd_en                    (reg_rd_en),
    .password_ok                  (password_ok),
    .power_fail_output_low        (power_fail_output_low),
    .switch1_enable               (switch1_enable),
    .switch1_on                   (switch1_on),
    .switch1_discharge            (switch1_discharge),
    .reg_rd_hit                   (reg_rd_hit),
    .reg_wr_rejected              (reg_wr_rejected),
    .shared_pin_warm_reset_select (shared_pin_warm_reset_select),
    .reg_addr                     (reg_addr),
    .reg_wr_data                  (reg_wr_data),
    .reg_rd_data                  (reg_rd_data)
);
`default_nettype wire

// >>> tb/load_switch_config_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module load_switch_config_regs_tb;
    logic sys_clk = 0, srst = 1, reg_wr_en = 0, reg_rd_en = 0, password_ok = 0;
    logic power_fail_output_low = 1;
    logic [2:0] en = 0;
    logic [7:0] reg_addr = 0, reg_wr_data = 0;
    wire logic [7:0] reg_rd_data;
    wire logic reg_rd_hit, reg_wr_rejected;
    wire logic shared_pin_warm_reset_select, lockout_hysteresis_select;
    wire logic [1:0] switch3_current_limit, switch2_current_limit;
    wire logic [2:0] on, dis;
    int fail_count = 0, cmp_count = 0;
    lsc_config_regs dut_u (.sys_clk, .srst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data,
        .password_ok, .power_fail_output_low, .switch1_enable(en[0]), .switch2_enable(en[1]),
        .switch3_enable(en[2]), .reg_rd_data, .reg_rd_hit, .reg_wr_rejected,
        .shared_pin_warm_reset_select, .lockout_hysteresis_select, .switch3_current_limit,
        .switch2_current_limit, .switch1_on(on[0]), .switch2_on(on[1]), .switch3_on(on[2]),
        .switch1_discharge(dis[0]), .switch2_discharge(dis[1]), .switch3_discharge(dis[2]));
    wire logic [7:0] cfg = {2'h0, shared_pin_warm_reset_select, lockout_hysteresis_select,
        switch3_current_limit, switch2_current_limit};
    initial forever #12.5 sys_clk = ~sys_clk;
    task automatic chk(string n, logic [7:0] got, logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s exp %h got %h", n, exp, got);
        end
    endtask
    // Outputs lag the register by one edge, so wait one more edge
    task automatic wr(logic [7:0] a, logic [7:0] d, logic p);
        @(posedge sys_clk);
        {reg_wr_en, reg_addr, reg_wr_data, password_ok} <= {1'h1, a, d, p};
        @(posedge sys_clk);
        reg_wr_en <= 1'h0;
        #1 chk("rej", {7'h0, reg_wr_rejected}, {7'h0, ~p});
        @(posedge sys_clk);
        #1;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge sys_clk);
        {reg_rd_en, reg_addr} <= {1'h1, a};
        @(posedge sys_clk);
        reg_rd_en <= 1'h0;
        #1 chk("rd", reg_rd_data, e);
        chk("hit", {7'h0, reg_rd_hit}, {7'h0, a == 8'h14 || a == 8'h15});
    endtask
    task automatic t_limit();
        logic [7:0] d;
        rd(8'h14, 8'hC0);
        chk("cfg", cfg, 8'h30);
        wr(8'h14, 8'h00, 1'h0);
        rd(8'h14, 8'hC0);
        for (int k = 0; k < 4; k++) begin
            d = {k[1:0], 2'h3, k[1:0], ~k[1:0]};
            wr(8'h14, d, 1'h1);
            chk("cfg", cfg, {2'h0, d[7:6], d[3:0]});
            rd(8'h14, d & 8'hCF);
        end
    endtask
    task automatic t_behav();
        logic [2:0] k;
        logic [2:0] r;
        logic [2:0] x;
        rd(8'h15, 8'h00);
        wr(8'h15, 8'hFF, 1'h1);
        rd(8'h15, 8'h3F);
        rd(8'h16, 8'h00);
        for (int i = 0; i < 6; i++) begin
            k = 3'h1 << (i / 2);
            r = {k[1:0], k[2]};
            wr(8'h15, {2'h0, k, k | r}, 1'h1);
            rd(8'h15, {2'h0, k, k | r});
            @(posedge sys_clk);
            {en, power_fail_output_low} <= {i[0] ? 3'h7 ^ r : 3'h7, i[0]};
            @(posedge sys_clk);
            #1 x = (i[0] ? 3'h7 ^ r : 3'h7) & ~(k & {3{~i[0]}});
            chk("on", on, x);
            chk("dis", dis, (k | r) & ~x);
        end
    endtask
    task automatic t_reset();
        wr(8'h14, 8'h0F, 1'h1);
        wr(8'h15, 8'h3F, 1'h1);
        @(posedge sys_clk);
        srst <= 1'h1;
        @(posedge sys_clk);
        srst <= 1'h0;
        #1 chk("cfg", cfg, 8'h30);
        chk("on", on, 8'h00);
        chk("dis", dis, 8'h00);
        rd(8'h14, 8'hC0);
        rd(8'h15, 8'h00);
    endtask
    task automatic end_sim();
        if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        srst <= 1'h0;
        t_limit();
        t_behav();
        t_reset();
        end_sim();
    end
endmodule // load_switch_config_regs_tb
`default_nettype wire
